//--- src/bridge_steer.v
// Notes on behaviour
// R1: Push-pull sends alternate input pulses to outputs A and B, never both.
// R2: Sequencer returns to start when disabled or on shutdown.
// R3: Input pulses advance the sequencer; first pulse after reset goes to A.
// R4: Push-pull C and D copy A and B, each with own polarity.
// R5: Forward bridge: A active, B and C inactive, D modulated.
// R6: Reverse bridge: C active, A and D inactive, B modulated.
// R7: A direction change in full-bridge inserts a dead-band interval.
// R8: Flipping only the low mode bit swaps direction while enabled.
// R9: Modulation input is synchronised to the clock before use.
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`include "bridge_steer_defines.vh"
module bridge_steer (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [31:0] s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [31:0] s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        modulation_in,
	input  wire        shutdown_in,
	output wire        drive_out_a,
	output wire        drive_out_b,
	output wire        drive_out_c,
	output wire        drive_out_d
);
	// Register state
	reg [7:0]           waveform_ctrl_first_q;
	reg [3:0]           waveform_ctrl_second_q;
	reg [`DB_WIDTH-1:0] db_forward_q;
	reg [`DB_WIDTH-1:0] db_reverse_q;
	reg                 soft_shutdown_q;
	reg                 shutdown_flag_q;

	// AXI state
	reg                 aw_got_q;
	reg                 w_got_q;
	reg [7:0]           aw_addr_q;
	reg [31:0]          w_data_q;
	reg [3:0]           w_strb_q;
	reg                 bvalid_q;
	reg [1:0]           bresp_q;
	reg                 rvalid_q;
	reg [1:0]           rresp_q;
	reg [31:0]          rdata_q;

	// Steering state
	reg                 mod_prev_q;
	reg                 next_b_q;
	reg                 cur_b_q;
	reg                 dir_rev_q;
	reg [3:0]           drive_q;

	wire [1:0]          sync_levels;
	wire                mod_sync;
	wire                sd_sync;
	wire                db_busy;
	wire                db_done;

	wire                enable;
	wire [2:0]          mode;
	wire                full_bridge;
	wire                want_rev;
	wire                shut_event;
	wire                seq_reset;
	wire                mod_rise;
	wire                pulse_to_b;
	wire                db_start;
	wire [`DB_WIDTH-1:0] db_count;
	wire                do_write;
	wire                ar_take;
	wire                sd_clear;

	function addr_mapped;
		input [7:0] a;
		begin
			addr_mapped = (a == `OFS_CTRL_FIRST) || (a == `OFS_CTRL_SECOND) ||
				(a == `OFS_DB_FORWARD) || (a == `OFS_DB_REVERSE) ||
				(a == `OFS_SHUTDOWN) || (a == `OFS_STATUS);
		end
	endfunction

	// R9 two-flop input sync
	level_sync #(
		.WIDTH    (2)
	) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({shutdown_in, modulation_in}),
		.sync_out (sync_levels)
	);

	assign mod_sync    = sync_levels[0];
	assign sd_sync     = sync_levels[1];
	assign enable      = waveform_ctrl_first_q[`CTRL_EN_BIT];
	assign mode        = waveform_ctrl_first_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB];
	assign full_bridge = (mode[2:1] == `MODE_BRIDGE_HI);
	assign want_rev    = mode[0];
	assign shut_event  = sd_sync | soft_shutdown_q;

	// AXI write channel: address and data taken in either order
	assign s_axi_awready = !aw_got_q && !bvalid_q;
	assign s_axi_wready  = !w_got_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign do_write      = aw_got_q && w_got_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q  <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q  <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= addr_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// Write-one-to-clear of the shutdown flag
	assign sd_clear = do_write && w_strb_q[0] && (aw_addr_q == `OFS_SHUTDOWN) && w_data_q[`SD_FLAG_BIT];

	// R8 mode bits rewritable while enabled
	always @(posedge aclk) begin
		if (!aresetn) begin
			waveform_ctrl_first_q  <= `RST_CTRL_FIRST;
			waveform_ctrl_second_q <= `RST_CTRL_SECOND;
			db_forward_q           <= `RST_DB_COUNT;
			db_reverse_q           <= `RST_DB_COUNT;
			soft_shutdown_q        <= 1'b0;
		end else if (do_write && w_strb_q[0]) begin
			case (aw_addr_q)
				`OFS_CTRL_FIRST: begin
					waveform_ctrl_first_q <= {w_data_q[7], 4'h0, w_data_q[2:0]};
				end
				`OFS_CTRL_SECOND: begin
					waveform_ctrl_second_q <= w_data_q[3:0];
				end
				`OFS_DB_FORWARD: begin
					db_forward_q <= w_data_q[`DB_WIDTH-1:0];
				end
				`OFS_DB_REVERSE: begin
					db_reverse_q <= w_data_q[`DB_WIDTH-1:0];
				end
				`OFS_SHUTDOWN: begin
					soft_shutdown_q <= w_data_q[`SD_SOFT_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// Sticky shutdown; a live event beats the clear
	always @(posedge aclk) begin
		if (!aresetn)
			shutdown_flag_q <= 1'b0;
		else if (shut_event)
			shutdown_flag_q <= 1'b1;
		else if (sd_clear)
			shutdown_flag_q <= 1'b0;
	end

	// AXI read channel
	assign ar_take       = s_axi_arvalid && !rvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rresp_q  <= `RESP_OKAY;
			rdata_q  <= 32'h00000000;
		end else if (ar_take) begin
			rvalid_q <= 1'b1;
			rresp_q  <= addr_mapped({s_axi_araddr[7:2], 2'b00}) ? `RESP_OKAY : `RESP_SLVERR;
			case ({s_axi_araddr[7:2], 2'b00})
				`OFS_CTRL_FIRST:  rdata_q <= {24'h000000, waveform_ctrl_first_q};
				`OFS_CTRL_SECOND: rdata_q <= {28'h0000000, waveform_ctrl_second_q};
				`OFS_DB_FORWARD:  rdata_q <= {{(32-`DB_WIDTH){1'b0}}, db_forward_q};
				`OFS_DB_REVERSE:  rdata_q <= {{(32-`DB_WIDTH){1'b0}}, db_reverse_q};
				`OFS_SHUTDOWN:    rdata_q <= {30'h00000000, shutdown_flag_q, soft_shutdown_q};
				`OFS_STATUS:      rdata_q <= {24'h000000, mod_sync, dir_rev_q, db_busy, next_b_q, drive_q};
				default:          rdata_q <= 32'h00000000;
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// R2 sequencer reset on disable or shutdown
	assign seq_reset  = !enable || shut_event || shutdown_flag_q;
	assign mod_rise   = mod_sync && !mod_prev_q;
	assign pulse_to_b = mod_rise ? next_b_q : cur_b_q;

	// R3 each rising input edge advances the sequencer, except while seq_reset holds it at start
	always @(posedge aclk) begin
		if (!aresetn) begin
			mod_prev_q <= 1'b0;
			next_b_q   <= 1'b0;
			cur_b_q    <= 1'b0;
		end else begin
			mod_prev_q <= mod_sync;
			if (seq_reset) begin
				next_b_q <= 1'b0;
				cur_b_q  <= 1'b0;
			end else if (mod_rise) begin
				cur_b_q  <= next_b_q;
				next_b_q <= !next_b_q;
			end
		end
	end

	// R7 dead band on forward/reverse change
	assign db_start = enable && full_bridge && !shutdown_flag_q && (want_rev != dir_rev_q);
	assign db_count = want_rev ? db_reverse_q : db_forward_q;

	dead_band_timer #(
		.WIDTH   (`DB_WIDTH)
	) u_db (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (db_start),
		.count   (db_count),
		.busy    (db_busy),
		.done    (db_done)
	);

	// When enabled in full-bridge, applied direction only changes after the dead band expires; otherwise it follows mode bit 0
	always @(posedge aclk) begin
		if (!aresetn)
			dir_rev_q <= 1'b0;
		else if (!enable || !full_bridge)
			dir_rev_q <= want_rev;
		else if (db_done)
			dir_rev_q <= want_rev;
	end

	// Output steering, logical active-high before polarity
	always @(posedge aclk) begin
		if (!aresetn) begin
			drive_q <= 4'h0;
		end else if (seq_reset || db_busy) begin
			drive_q <= 4'h0;
		end else begin
			case (mode)
				`MODE_PUSH_PULL: begin
					// R1 R4 one pulse per output, C/D mirror A/B
					drive_q <= {mod_sync && pulse_to_b, mod_sync && !pulse_to_b,
						mod_sync && pulse_to_b, mod_sync && !pulse_to_b};
				end
				`MODE_FWD_BRIDGE, `MODE_REV_BRIDGE: begin
					// R5 R6 static pair plus one modulated output
					if (dir_rev_q)
						drive_q <= {1'b0, 1'b1, mod_sync, 1'b0};
					else
						drive_q <= {mod_sync, 1'b0, 1'b0, 1'b1};
				end
				`MODE_HALF_BRIDGE: begin
					drive_q <= {!mod_sync, mod_sync, !mod_sync, mod_sync};
				end
				default: begin
					drive_q <= 4'h0;
				end
			endcase
		end
	end

	// Polarity applied at the pins; a set bit makes the output active low
	assign drive_out_a = drive_q[0] ^ waveform_ctrl_second_q[`POL_A_BIT];
	assign drive_out_b = drive_q[1] ^ waveform_ctrl_second_q[`POL_B_BIT];
	assign drive_out_c = drive_q[2] ^ waveform_ctrl_second_q[`POL_C_BIT];
	assign drive_out_d = drive_q[3] ^ waveform_ctrl_second_q[`POL_D_BIT];
endmodule // bridge_steer

//--- src/bridge_steer_defines.vh
`ifndef BRIDGE_STEER_DEFINES_VH
`define BRIDGE_STEER_DEFINES_VH

// Register byte offsets
`define OFS_CTRL_FIRST      8'h00
`define OFS_CTRL_SECOND     8'h04
`define OFS_DB_FORWARD      8'h08
`define OFS_DB_REVERSE      8'h0C
`define OFS_SHUTDOWN        8'h10
`define OFS_STATUS          8'h14

// Field positions
`define CTRL_EN_BIT         7
`define CTRL_MODE_MSB       2
`define CTRL_MODE_LSB       0
`define POL_A_BIT           0
`define POL_B_BIT           1
`define POL_C_BIT           2
`define POL_D_BIT           3
`define SD_SOFT_BIT         0
`define SD_FLAG_BIT         1

// Mode encodings
`define MODE_HALF_BRIDGE    3'h0
`define MODE_FWD_BRIDGE     3'h2
`define MODE_REV_BRIDGE     3'h3
`define MODE_PUSH_PULL      3'h4
`define MODE_BRIDGE_HI      2'h1

// Reset values
`define RST_CTRL_FIRST      8'h00
`define RST_CTRL_SECOND     4'h0
`define RST_DB_COUNT        6'h00

// Timing
`define DB_WIDTH            6

// AXI responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

//--- src/dead_band_timer.v
`timescale 1ns/100ps
`include "bridge_steer_defines.vh"
module dead_band_timer #(
	parameter WIDTH = `DB_WIDTH
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire             start,
	input  wire [WIDTH-1:0] count,
	output wire             busy,
	output wire             done
);
	reg             busy_q;
	reg [WIDTH-1:0] cnt_q;

	// Interval is count+1 cycles so a zero count still breaks the overlap
	always @(posedge aclk) begin
		if (!aresetn) begin
			busy_q <= 1'b0;
			cnt_q  <= {WIDTH{1'b0}};
		end else if (start && !busy_q) begin
			busy_q <= 1'b1;
			cnt_q  <= count;
		end else if (busy_q) begin
			if (cnt_q == {WIDTH{1'b0}})
				busy_q <= 1'b0;
			else
				cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	assign busy = busy_q;
	assign done = busy_q && (cnt_q == {WIDTH{1'b0}});
endmodule // dead_band_timer

//--- src/level_sync.v
`timescale 1ns/100ps
module level_sync #(
	parameter WIDTH = 2
) (
	input  wire             aclk,
	input  wire             aresetn,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// Only the second stage is visible to logic
	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule // level_sync

//--- tb/bridge_steer_bench.sv
`timescale 1ns/100ps
module bridge_steer_bench;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, modulation_in, shutdown_in;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, d;
	logic [3:0]  pol;
	logic [2:0]  mode;
	logic [1:0]  r;
	logic        en, sdf, sel, nxb;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire         drive_out_a, drive_out_b, drive_out_c, drive_out_d;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata;
	wire [15:0]  overlaps;
	integer      errors = 0, total_checks = 0, seed = 11355, i;
	bridge_steer dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .modulation_in, .shutdown_in, .drive_out_a,
		.drive_out_b, .drive_out_c, .drive_out_d);
	switch_stage sw_u (.aclk, .leg_a(drive_out_a), .leg_b(drive_out_b), .overlaps);
	initial begin
		aclk = 0;
		forever #4 aclk = ~aclk;
	end
	task automatic test_done;
		if (errors == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (e !== g) begin
			errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	// Bounded wait on one ready or valid, looked at just after an edge; returns at the taking edge
	task automatic hs(input integer w);
		integer k;
		logic   seen;
		seen = 0;
		for (k = 0; k < 40 && !seen; k++) begin
			#1;
			case (w)
				0: seen = s_axi_arready;
				1: seen = s_axi_bvalid;
				default: seen = s_axi_rvalid;
			endcase
			@(posedge aclk);
		end
		if (!seen) begin
			errors++;
			test_done;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic   pa, pb, ta, tw;
		integer k;
		@(posedge aclk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		pa = 1;
		pb = 1;
		// Each half released at the edge that takes it
		for (k = 0; k < 40 && (pa || pb); k++) begin
			#1;
			ta = pa && s_axi_awready;
			tw = pb && s_axi_wready;
			@(posedge aclk);
			if (ta) begin
				pa = 0;
				s_axi_awvalid <= 0;
			end
			if (tw) begin
				pb = 0;
				s_axi_wvalid <= 0;
			end
		end
		if (pa || pb) begin
			errors++;
			test_done;
		end
		hs(1);
		rs = s_axi_bresp;
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		hs(0);
		s_axi_arvalid <= 0;
		hs(2);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 0;
	endtask
	function automatic logic [3:0] exp_pins(input logic m);
		logic [3:0] l;
		l = 4'h0;
		if (en && !sdf)
			case (mode)
				3'h4: l = {m & sel, m & !sel, m & sel, m & !sel};
				3'h2: l = {m, 1'b0, 1'b0, 1'b1};
				3'h3: l = {1'b0, 1'b1, m, 1'b0};
				3'h0: l = {!m, m, !m, m};
			endcase
		return l ^ pol;
	endfunction
	// Pulses steer alternately, from A
	task automatic lvl(input logic m);
		@(posedge aclk);
		modulation_in <= m;
		if (m && mode == 3'h4 && en && !sdf) begin
			sel = nxb;
			nxb = !nxb;
		end
		repeat (5) @(posedge aclk);
		#1 chk("pins", exp_pins(m), {drive_out_d, drive_out_c, drive_out_b, drive_out_a});
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{aresetn, modulation_in, shutdown_in, en, sdf, sel, nxb} = 7'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		pol = 4'h0;
		mode = 3'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		rd(8'h00, d, r);
		chk("ctrl_first", 32'h0, d);
		rd(8'h40, d, r);
		chk("rresp", 2'h2, r);
		wr(8'h40, 32'h1, r);
		chk("bresp", 2'h2, r);
		// Legs A and B unflipped for the stage
		pol = $random(seed) & 4'hC;
		wr(8'h04, {28'h0, pol}, r);
		rd(8'h04, d, r);
		chk("ctrl_second", {28'h0, pol}, d);
		{en, mode} = 4'hC;
		wr(8'h00, 32'h84, r);
		for (i = 0; i < 3 + ($random(seed) & 3); i++) begin
			lvl(1);
			lvl(0);
		end
		en = 0;
		nxb = 0;
		wr(8'h00, 32'h04, r);
		lvl(1);
		lvl(0);
		en = 1;
		wr(8'h00, 32'h84, r);
		lvl(1);
		lvl(0);
		@(posedge aclk);
		shutdown_in <= 1;
		sdf = 1;
		nxb = 0;
		lvl(1);
		lvl(0);
		@(posedge aclk);
		shutdown_in <= 0;
		repeat (4) @(posedge aclk);
		wr(8'h10, 32'h2, r);
		sdf = 0;
		lvl(1);
		lvl(0);
		wr(8'h0C, 32'h14, r);
		wr(8'h08, 32'h2, r);
		mode = 3'h2;
		wr(8'h00, 32'h82, r);
		lvl(1);
		lvl(0);
		wr(8'h00, 32'h83, r);
		// Old direction holds one cycle before the dead band blanks the outputs
		@(posedge aclk);
		#1 chk("dead band pins", pol, {drive_out_d, drive_out_c, drive_out_b, drive_out_a});
		rd(8'h14, d, r);
		chk("dead band flag", 1'b1, d[5]);
		mode = 3'h3;
		repeat (25) @(posedge aclk);
		lvl(1);
		lvl(0);
		rd(8'h14, d, r);
		chk("reverse flag", 1'b1, d[6]);
		mode = 3'h2;
		wr(8'h00, 32'h82, r);
		@(posedge aclk);
		#1 chk("forward dead band pins", pol, {drive_out_d, drive_out_c, drive_out_b, drive_out_a});
		repeat (6) @(posedge aclk);
		lvl(1);
		mode = 3'h0;
		wr(8'h00, 32'h80, r);
		lvl(0);
		lvl(1);
		chk("overlaps", 16'h0, overlaps);
		test_done;
	end
endmodule // bridge_steer_bench
bind bridge_steer bridge_steer_checker chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready, .drive_out_a, .drive_out_b, .drive_out_c, .drive_out_d);

//--- tb/bridge_steer_checker.sv
`timescale 1ns/100ps
module bridge_steer_checker (
	input wire        aclk,
	input wire        aresetn,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        drive_out_a,
	input wire        drive_out_b,
	input wire        drive_out_c,
	input wire        drive_out_d
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_resp;
		!s_axi_bvalid ##1 s_axi_bvalid;
	endsequence
	property p_wr_resp;
		s_wr_both |=> s_resp;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late or early");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_b_drop;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_drop: assert property (p_b_drop) else $error("write response repeated");
	property p_w_block;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_w_block: assert property (p_w_block) else $error("write taken during response");
	property p_rd_resp;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read response late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data changed");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken during response");
	property p_reset;
		disable iff (1'b0) !aresetn |=> !drive_out_a && !drive_out_b && !drive_out_c && !drive_out_d
			&& !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs active after reset");
endmodule // bridge_steer_checker

//--- tb/switch_stage.sv
`timescale 1ns/100ps
module switch_stage (
	input  wire         aclk,
	input  wire         leg_a,
	input  wire         leg_b,
	output logic [15:0] overlaps
);
	initial overlaps = 16'h0000;
	always @(posedge aclk) begin
		if (leg_a && leg_b)
			overlaps <= overlaps + 16'h0001;
	end
endmodule // switch_stage
